// ---- shared/haptic_tuning_pkg.sv ----
package haptic_tuning_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int DUR_W  = 16;

	// register offsets
	localparam logic [7:0] NEG_SUSTAIN_OFS   = 8'h1C;
	localparam logic [7:0] BRAKE_OFS         = 8'h1D;
	localparam logic [7:0] FULL_SCALE_OFS    = 8'h1F;
	localparam logic [7:0] OD_LIMIT_OFS      = 8'h20;
	localparam logic [7:0] LOSS_COMP_OFS     = 8'h21;
	localparam logic [7:0] GAIN_BASIS_OFS    = 8'h22;

	// reset values
	localparam logic [7:0] NEG_SUSTAIN_RST   = 8'h00;
	localparam logic [7:0] BRAKE_RST         = 8'h00;
	localparam logic [7:0] FULL_SCALE_RST    = 8'h3F;
	localparam logic [7:0] OD_LIMIT_RST      = 8'h89;
	localparam logic [7:0] LOSS_COMP_RST     = 8'h0D;
	localparam logic [7:0] GAIN_BASIS_RST    = 8'h6D;
	localparam logic [7:0] READ_ZERO         = 8'h00;

	localparam logic [15:0] DUR_ZERO         = 16'h0000;
	localparam logic [7:0]  LEVEL_ZERO       = 8'h00;

	// host control port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} host_req_type;

	// one library waveform sample as the playback engine presents it
	typedef struct packed {
		logic              valid;
		logic signed [7:0] level;
		logic [DUR_W-1:0]  steps;
		logic signed [7:0] wave_max;
		logic signed [7:0] wave_min;
	} sample_type;

	// calibration result
	typedef struct packed {
		logic       done;
		logic [7:0] loss_comp;
		logic [7:0] gain_basis;
	} calib_type;

	typedef enum logic [1:0] {
		PORTION_OVERDRIVE,
		PORTION_BRAKE,
		PORTION_NEG_SUSTAIN,
		PORTION_OTHER
	} portion_type;

endpackage

// ---- testbench/host_ctrl_model.sv ----
module host_ctrl_model (
	// clock
	input  wire logic                        core_clk,
	// control port
	output haptic_tuning_pkg::host_req_type  host_req,
	input  wire logic [7:0]                  host_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial host_req = '0;

	// one-cycle strobe, then idle lines flip so stale values never match
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		host_req.wr    = 1'b1;
		host_req.addr  = a;
		host_req.wdata = d;
		@(posedge core_clk) #1;
		host_req.wr    = 1'b0;
		host_req.addr  = ~a;
		host_req.wdata = ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk) #1;
		host_req.rd   = 1'b1;
		host_req.addr = a;
		@(posedge core_clk) #1;
		host_req.rd   = 1'b0;
		host_req.addr = ~a;
		d             = host_rdata;
	endtask
endmodule // host_ctrl_model

// ---- testbench/testbench.sv ----
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                            core_clk;
	logic                            rst_b;
	logic                            closed_loop;
	logic                            sample_out_valid;
	logic [15:0]                     sample_out_steps;
	logic [7:0]                      host_rdata, drive_req, drive_level;
	logic [7:0]                      full_scale, gain_basis, calib_full_scale;
	logic [7:0]                      ofs [6];
	logic [7:0]                      rv [6];
	haptic_tuning_pkg::host_req_type host_req;
	haptic_tuning_pkg::sample_type   sample_in;
	haptic_tuning_pkg::calib_type    calib_in;
	int                              n_errors, checks, cycles;

	////////////////////////////////////////////////////////////////////
	host_ctrl_model host (
		.core_clk   (core_clk),
		.host_req   (host_req),
		.host_rdata (host_rdata)
	);

	haptic_waveform_tuning_regs uut (
		.core_clk         (core_clk),
		.rst_b            (rst_b),
		.host_req         (host_req),
		.host_rdata       (host_rdata),
		.closed_loop      (closed_loop),
		.sample_in        (sample_in),
		.drive_req        (drive_req),
		.sample_out_valid (sample_out_valid),
		.sample_out_steps (sample_out_steps),
		.drive_level      (drive_level),
		.full_scale       (full_scale),
		.gain_basis       (gain_basis),
		.calib_in         (calib_in),
		.calib_full_scale (calib_full_scale)
	);

	////////////////////////////////////////////////////////////////////
	always #5 core_clk = ~core_clk;

	// run needs well under 1000 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	// waveform extremes fixed at +5 and -8
	task automatic samp(input logic cl, input logic [7:0] lv,
			input logic [15:0] st, es, input logic [7:0] dq, ed);
		@(posedge core_clk) #1;
		closed_loop = cl;
		drive_req   = dq;
		sample_in   = '{1'b1, lv, st, 8'h05, 8'hF8};
		@(posedge core_clk) #1;
		sample_in.valid = 1'b0;
		chk("valid", {15'h0000, sample_out_valid}, 16'h0001);
		chk("steps", sample_out_steps, es);
		chk("drive", {8'h00, drive_level}, {8'h00, ed});
	endtask

	task automatic calib(input logic [7:0] lc, gb);
		@(posedge core_clk) #1;
		calib_in = '{1'b1, lc, gb};
		@(posedge core_clk) #1;
		calib_in.done = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d;
		core_clk    = 1'b0;
		rst_b       = 1'b0;
		closed_loop = 1'b0;
		drive_req   = 8'h00;
		sample_in   = '0;
		calib_in    = '0;
		ofs = '{8'h1C, 8'h1D, 8'h1F, 8'h20, 8'h21, 8'h22};
		rv  = '{8'h00, 8'h00, 8'h3F, 8'h89, 8'h0D, 8'h6D};
		repeat (12) @(posedge core_clk);
		#1 rst_b = 1'b1;
		foreach (ofs[i]) begin
			host.read_reg(ofs[i], d);
			chk("reset", {8'h00, d}, {8'h00, rv[i]});
			host.write_reg(ofs[i], ~rv[i]);
			host.read_reg(ofs[i], d);
			chk("rw", {8'h00, d}, {8'h00, ~rv[i]});
		end
		host.read_reg(8'h1E, d);
		chk("unmapped", {8'h00, d}, 16'h0000);
		host.write_reg(8'h1C, 8'hFE);
		host.write_reg(8'h1D, 8'h03);
		host.write_reg(8'h20, 8'h60);
		samp(1'b0, 8'hFD, 16'h000A, 16'h0008, 8'h40, 8'h40);
		samp(1'b0, 8'h05, 16'h000A, 16'h000A, 8'hF0, 8'hF0);
		samp(1'b0, 8'hF8, 16'h000A, 16'h000D, 8'hF0, 8'hF0);
		samp(1'b1, 8'hF8, 16'h000A, 16'h000A, 8'hF0, 8'h60);
		samp(1'b1, 8'h05, 16'h000A, 16'h000A, 8'hF0, 8'h60);
		samp(1'b1, 8'h02, 16'h000A, 16'h000A, 8'hF0, 8'hF0);
		samp(1'b0, 8'hFD, 16'h0001, 16'h0000, 8'h10, 8'h10);
		// zero offset leaves sustain alone; a long one saturates
		host.write_reg(8'h1C, 8'h00);
		samp(1'b0, 8'hFD, 16'h000A, 16'h000A, 8'h10, 8'h10);
		host.write_reg(8'h1C, 8'h7F);
		samp(1'b0, 8'hFD, 16'hFFF0, 16'hFFFF, 8'h10, 8'h10);
		// reference first, since calibration reads it
		host.write_reg(8'h1F, 8'h50);
		chk("fs", {8'h00, full_scale}, 16'h0050);
		chk("cfs", {8'h00, calib_full_scale}, 16'h0050);
		calib(8'h22, 8'h44);
		chk("gain", {8'h00, gain_basis}, 16'h0044);
		host.read_reg(8'h21, d);
		chk("comp", {8'h00, d}, 16'h0022);
		host.write_reg(8'h1F, 8'h60);
		calib(8'h11, 8'h55);
		host.read_reg(8'h22, d);
		chk("gain2", {8'h00, d}, 16'h0055);
		print_verdict();
	end
endmodule // testbench

// ---- verilog/haptic_waveform_tuning_regs.sv ----
// How it works
// R1 - negative-sustain samples gain a signed count of step periods.
// R2 - a negative sample other than the maximum and the minimum counts as negative sustain.
// R3 - braking samples gain a signed count of step periods.
// R4 - braking samples are those at the waveform's most negative level.
// R5 - the brake offset acts only in open loop and is ignored in closed loop.
// R6 - the full-scale reference sets closed-loop full scale, reset 63.
// R7 - the host loads the full-scale reference before starting calibration.
// R8 - the host recalibrates after changing the full-scale reference.
// R9 - closed-loop overdrive and brake drive is held to a limit, reset 137.
// R10 - a finished calibration stores the loss compensation result, reset 13.
// R11 - calibration derives the loss compensation from measured impedance.
// R12 - the closed-loop feedback gain comes from its register, reset 109.
// R13 - the waveform's maximum sample is overdrive and never sustain.
// R14 - a negative offset longer than the portion gives zero, not a wrap.
module haptic_waveform_tuning_regs (
	// clock and reset
	input  wire logic                            core_clk,
	input  wire logic                            rst_b,
	// host control port
	input  wire haptic_tuning_pkg::host_req_type host_req,
	output logic [7:0]                           host_rdata,
	// playback engine
	input  wire logic                            closed_loop,
	input  wire haptic_tuning_pkg::sample_type   sample_in,
	input  wire logic [7:0]                      drive_req,
	output logic                                 sample_out_valid,
	output logic [15:0]                          sample_out_steps,
	output logic [7:0]                           drive_level,
	output logic [7:0]                           full_scale,
	output logic [7:0]                           gain_basis,
	// calibration engine
	input  wire haptic_tuning_pkg::calib_type    calib_in,
	output logic [7:0]                           calib_full_scale
);

	logic [7:0]  neg_sustain_r;
	logic [7:0]  brake_r;
	logic [7:0]  full_scale_r;
	logic [7:0]  od_limit_r;
	logic [7:0]  loss_comp_r;
	logic [7:0]  gain_basis_r;
	logic [7:0]  rdata_nxt;
	haptic_tuning_pkg::portion_type portion;
	logic [7:0]  ofs_sel;
	logic        ofs_en;
	logic [15:0] adj_steps;
	logic        boost;

	////////////////////////////////////////////////////////////////////////
	// register writes

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			neg_sustain_r <= haptic_tuning_pkg::NEG_SUSTAIN_RST;
			brake_r       <= haptic_tuning_pkg::BRAKE_RST;
			full_scale_r  <= haptic_tuning_pkg::FULL_SCALE_RST; // see R6
			od_limit_r    <= haptic_tuning_pkg::OD_LIMIT_RST; // see R9
		end else if (host_req.wr) begin
			case (host_req.addr)
				haptic_tuning_pkg::NEG_SUSTAIN_OFS:
					neg_sustain_r <= host_req.wdata;
				haptic_tuning_pkg::BRAKE_OFS:
					brake_r <= host_req.wdata;
				haptic_tuning_pkg::FULL_SCALE_OFS:
					full_scale_r <= host_req.wdata;
				haptic_tuning_pkg::OD_LIMIT_OFS:
					od_limit_r <= host_req.wdata;
				default: ;
			endcase
		end
	end

	// calibration result wins over a host write in the same cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loss_comp_r  <= haptic_tuning_pkg::LOSS_COMP_RST; // see R10
			gain_basis_r <= haptic_tuning_pkg::GAIN_BASIS_RST; // see R12
		end else if (calib_in.done) begin
			loss_comp_r  <= calib_in.loss_comp; // see R10, R11
			gain_basis_r <= calib_in.gain_basis;
		end else if (host_req.wr) begin
			if (host_req.addr == haptic_tuning_pkg::LOSS_COMP_OFS)
				loss_comp_r <= host_req.wdata;
			if (host_req.addr == haptic_tuning_pkg::GAIN_BASIS_OFS)
				gain_basis_r <= host_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads, registered one cycle after rd

	always_comb begin
		case (host_req.addr)
			haptic_tuning_pkg::NEG_SUSTAIN_OFS: rdata_nxt = neg_sustain_r;
			haptic_tuning_pkg::BRAKE_OFS:       rdata_nxt = brake_r;
			haptic_tuning_pkg::FULL_SCALE_OFS:  rdata_nxt = full_scale_r;
			haptic_tuning_pkg::OD_LIMIT_OFS:    rdata_nxt = od_limit_r;
			haptic_tuning_pkg::LOSS_COMP_OFS:   rdata_nxt = loss_comp_r;
			haptic_tuning_pkg::GAIN_BASIS_OFS:  rdata_nxt = gain_basis_r;
			default: rdata_nxt = haptic_tuning_pkg::READ_ZERO;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			host_rdata <= haptic_tuning_pkg::READ_ZERO;
		else if (host_req.rd)
			host_rdata <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// sample classification

	always_comb begin
		if (sample_in.level == sample_in.wave_max)
			portion = haptic_tuning_pkg::PORTION_OVERDRIVE; // see R13
		else if (sample_in.level == sample_in.wave_min && sample_in.level < 0)
			portion = haptic_tuning_pkg::PORTION_BRAKE; // see R4
		else if (sample_in.level < 0)
			portion = haptic_tuning_pkg::PORTION_NEG_SUSTAIN; // see R2
		else
			portion = haptic_tuning_pkg::PORTION_OTHER;
	end

	// brake offset only in open loop; closed loop brakes on its own
	always_comb begin
		case (portion)
			haptic_tuning_pkg::PORTION_NEG_SUSTAIN: begin
				ofs_sel = neg_sustain_r; // see R1
				ofs_en  = 1'b1;
			end
			haptic_tuning_pkg::PORTION_BRAKE: begin
				ofs_sel = brake_r; // see R3
				ofs_en  = !closed_loop; // see R5
			end
			default: begin
				ofs_sel = haptic_tuning_pkg::READ_ZERO;
				ofs_en  = 1'b0;
			end
		endcase
	end

	// lengths are in step periods, so the offset adds directly
	step_offset_adjust u_adjust (
		.base_steps (sample_in.steps),
		.offset     (ofs_sel),
		.enable     (ofs_en),
		.adj_steps  (adj_steps)
	);

	////////////////////////////////////////////////////////////////////////
	// playback outputs

	assign boost = closed_loop
		&& (portion == haptic_tuning_pkg::PORTION_OVERDRIVE
		|| portion == haptic_tuning_pkg::PORTION_BRAKE);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_out_valid <= 1'b0;
			sample_out_steps <= haptic_tuning_pkg::DUR_ZERO;
			drive_level      <= haptic_tuning_pkg::LEVEL_ZERO;
		end else begin
			sample_out_valid <= sample_in.valid;
			sample_out_steps <= adj_steps;
			if (boost && drive_req > od_limit_r)
				drive_level <= od_limit_r; // see R9
			else
				drive_level <= drive_req;
		end
	end

	// reference copies for closed loop and calibration
	assign full_scale       = full_scale_r; // see R6
	assign calib_full_scale = full_scale_r; // see R7
	assign gain_basis       = gain_basis_r; // see R12

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_boost_over;
		boost && drive_req > od_limit_r;
	endsequence

	property p_overdrive_output_limit;
		@(posedge core_clk) disable iff (!rst_b)
		s_boost_over |=> drive_level == $past(od_limit_r);
	endproperty
	a_overdrive_output_limit: assert property (p_overdrive_output_limit) // see R9
		else $error("overdrive limit not applied");

	property p_brake_closed;
		@(posedge core_clk) disable iff (!rst_b)
		(closed_loop && portion == haptic_tuning_pkg::PORTION_BRAKE)
		|=> sample_out_steps == $past(sample_in.steps);
	endproperty
	a_brake_closed: assert property (p_brake_closed) // see R5
		else $error("brake offset used in closed loop");

	property p_zero_floor;
		@(posedge core_clk) disable iff (!rst_b)
		(ofs_en && $signed({1'b0, sample_in.steps})
			+ $signed(ofs_sel) < 0) |=> sample_out_steps == 16'h0000;
	endproperty
	a_zero_floor: assert property (p_zero_floor) // see R14
		else $error("negative offset wrapped");

	property p_overdrive_untouched;
		@(posedge core_clk) disable iff (!rst_b)
		(portion == haptic_tuning_pkg::PORTION_OVERDRIVE)
		|=> sample_out_steps == $past(sample_in.steps);
	endproperty
	a_overdrive_untouched: assert property (p_overdrive_untouched) // see R13
		else $error("overdrive sample adjusted");

	property p_neg_sustain;
		@(posedge core_clk) disable iff (!rst_b)
		(portion == haptic_tuning_pkg::PORTION_NEG_SUSTAIN
			&& neg_sustain_r == 8'h00)
		|=> sample_out_steps == $past(sample_in.steps);
	endproperty
	a_neg_sustain: assert property (p_neg_sustain) // see R1
		else $error("zero sustain offset changed length");

	property p_neg_class;
		@(posedge core_clk) disable iff (!rst_b)
		(sample_in.level < 0 && sample_in.level != sample_in.wave_max
			&& sample_in.level != sample_in.wave_min)
		|-> ofs_sel == neg_sustain_r && ofs_en;
	endproperty
	a_neg_class: assert property (p_neg_class) // see R2
		else $error("negative sample not sustain");

	property p_calib_store;
		@(posedge core_clk) disable iff (!rst_b)
		calib_in.done |=> loss_comp_r == $past(calib_in.loss_comp)
			&& gain_basis_r == $past(calib_in.gain_basis);
	endproperty
	a_calib_store: assert property (p_calib_store) // see R10
		else $error("calibration result not stored");

	property p_full_scale_write;
		@(posedge core_clk) disable iff (!rst_b)
		(host_req.wr && host_req.addr == haptic_tuning_pkg::FULL_SCALE_OFS)
		|=> full_scale == $past(host_req.wdata);
	endproperty
	a_full_scale_write: assert property (p_full_scale_write) // see R6
		else $error("full scale write lost");

endmodule // haptic_waveform_tuning_regs

// ---- verilog/step_offset_adjust.sv ----
module step_offset_adjust (
	// base length and signed offset
	input  wire logic [15:0] base_steps,
	input  wire logic [7:0]  offset,
	input  wire logic        enable,
	// adjusted length
	output logic      [15:0] adj_steps
);

	logic signed [17:0] sum;

	// clamp at zero instead of wrapping
	always_comb begin
		sum = $signed({2'b00, base_steps}) + 18'($signed(offset));
		if (!enable)
			adj_steps = base_steps;
		else if (sum < 0)
			adj_steps = haptic_tuning_pkg::DUR_ZERO; // see R14
		else if (sum[17:16] != 2'b00)
			adj_steps = '1;
		else
			adj_steps = sum[15:0];
	end

endmodule // step_offset_adjust
